// [src/pac_port_cfg.sv]
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/10ps
module pac_port_cfg #(
    parameter int NUM_PINS = 6
) (
    // Clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                clk_en,
    // AXI4-Lite write
    input  wire logic [3:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // Port side
    input  wire logic                global_pullup_disable,
    input  wire logic [NUM_PINS-1:0] pin_direction_bit,
    input  wire logic [NUM_PINS-1:0] pin_in,
    input  wire logic [NUM_PINS-1:0] drive_data,
    // Pad controls and synchronised port value
    output logic [NUM_PINS-1:0]      pad_out,
    output logic [NUM_PINS-1:0]      pad_oe,
    output logic [NUM_PINS-1:0]      pad_in_buf_en,
    output logic [NUM_PINS-1:0]      pad_pullup_en,
    output logic [NUM_PINS-1:0]      pad_slew_limit,
    output logic [NUM_PINS-1:0]      port_value
);

    if (NUM_PINS != 6) begin : g_bad_pins
        $error("pac_port_cfg supports six pins only");
    end

    // -----------------------------------------------------------------
    // Configuration registers
    // -----------------------------------------------------------------
    logic [7:0] analog_select_ff;
    logic [7:0] weak_pullup_enable_ff;
    logic [7:0] open_drain_enable_ff;
    logic [7:0] slew_limit_enable_ff;

    logic [3:0] aw_addr_ff;
    logic       aw_held_ff;
    logic [7:0] w_data_ff;
    logic       w_lane0_ff;
    logic       w_held_ff;
    logic       do_write;
    logic       write_hit;

    assign do_write  = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign write_hit = (aw_addr_ff == pac_pkg::ADDR_ANALOG_SELECT) ||
                       (aw_addr_ff == pac_pkg::ADDR_WEAK_PULLUP) ||
                       (aw_addr_ff == pac_pkg::ADDR_OPEN_DRAIN) ||
                       (aw_addr_ff == pac_pkg::ADDR_SLEW_LIMIT);

    // -----------------------------------------------------------------
    // Write channels
    // -----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff    <= 1'b0;
            aw_addr_ff    <= 4'h0;
            s_axi_awready <= 1'b0;
        end else if (clk_en) begin
            s_axi_awready <= !aw_held_ff && !s_axi_awready && s_axi_awvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_ff    <= 1'b0;
            w_data_ff    <= 8'h00;
            w_lane0_ff   <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (clk_en) begin
            s_axi_wready <= !w_held_ff && !s_axi_wready && s_axi_wvalid;
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff  <= 1'b1;
                w_data_ff  <= s_axi_wdata[7:0];
                w_lane0_ff <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pac_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= write_hit ? pac_pkg::RESP_OKAY
                                          : pac_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // Register storage
    // -----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_select_ff      <= pac_pkg::RST_ANALOG;
            weak_pullup_enable_ff <= pac_pkg::RST_PULLUP;
            open_drain_enable_ff  <= pac_pkg::RST_OPEN_DRAIN;
            slew_limit_enable_ff  <= pac_pkg::RST_SLEW;
        end else if (clk_en && do_write && w_lane0_ff) begin
            unique case (aw_addr_ff)
                pac_pkg::ADDR_ANALOG_SELECT: begin
                    analog_select_ff <= w_data_ff & pac_pkg::MASK_ANALOG;
                end
                pac_pkg::ADDR_WEAK_PULLUP: begin
                    weak_pullup_enable_ff <= w_data_ff & pac_pkg::MASK_PULLUP;
                end
                pac_pkg::ADDR_OPEN_DRAIN: begin
                    open_drain_enable_ff <= w_data_ff & pac_pkg::MASK_DRIVE;
                end
                pac_pkg::ADDR_SLEW_LIMIT: begin
                    slew_limit_enable_ff <= w_data_ff & pac_pkg::MASK_DRIVE;
                end
                default: begin
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Read channel
    // -----------------------------------------------------------------
    logic [7:0] nxt_rdata;
    logic       read_hit;

    always_comb begin
        nxt_rdata = 8'h00;
        read_hit  = 1'b1;
        unique case (s_axi_araddr)
            pac_pkg::ADDR_ANALOG_SELECT: nxt_rdata = analog_select_ff;
            pac_pkg::ADDR_WEAK_PULLUP:   nxt_rdata = weak_pullup_enable_ff;
            pac_pkg::ADDR_OPEN_DRAIN:    nxt_rdata = open_drain_enable_ff;
            pac_pkg::ADDR_SLEW_LIMIT:    nxt_rdata = slew_limit_enable_ff;
            default:                     read_hit  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= pac_pkg::RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h00_0000, nxt_rdata};
                s_axi_rresp  <= read_hit ? pac_pkg::RESP_OKAY
                                         : pac_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // Pin input synchroniser
    // -----------------------------------------------------------------
    logic [NUM_PINS-1:0] sync1_ff;
    logic [NUM_PINS-1:0] sync2_ff;
    logic [NUM_PINS-1:0] sync3_ff;
    logic [NUM_PINS-1:0] pin_stable_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_ff      <= '0;
            sync2_ff      <= '0;
            sync3_ff      <= '0;
            pin_stable_ff <= '0;
        end else if (clk_en) begin
            sync1_ff <= pin_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pin_stable_ff <= (sync2_ff & sync3_ff) |
                             (pin_stable_ff & (sync2_ff | sync3_ff));
        end
    end

    // -----------------------------------------------------------------
    // Per-pin pad control
    // -----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
            logic is_output;
            logic analog;
            assign is_output = !pin_direction_bit[gi];
            assign analog    = analog_select_ff[gi];

            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pad_out[gi]        <= 1'b0;
                    pad_oe[gi]         <= 1'b0;
                    pad_in_buf_en[gi]  <= 1'b0;
                    pad_pullup_en[gi]  <= 1'b0;
                    pad_slew_limit[gi] <= 1'b1;
                    port_value[gi]     <= 1'b0;
                end else if (clk_en) begin
                    // Output drive kept in analog mode too
                    if (open_drain_enable_ff[gi]) begin
                        pad_out[gi] <= 1'b0;
                        pad_oe[gi]  <= is_output && !drive_data[gi];
                    end else begin
                        pad_out[gi] <= drive_data[gi];
                        pad_oe[gi]  <= is_output;
                    end
                    pad_in_buf_en[gi]  <= !analog;
                    pad_pullup_en[gi]  <= weak_pullup_enable_ff[gi] &&
                                          !global_pullup_disable &&
                                          !is_output;
                    pad_slew_limit[gi] <= slew_limit_enable_ff[gi];
                    port_value[gi]     <= analog ? 1'b0
                                                 : pin_stable_ff[gi];
                end
            end
        end
    endgenerate

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_analog_buf_off: assert property (
        clk_en && analog_select_ff[0] |=> !pad_in_buf_en[0])
        else $error("input buffer on in analog mode");
    chk_digital_buf_on: assert property (
        clk_en && !analog_select_ff[1] |=> pad_in_buf_en[1])
        else $error("input buffer off in digital mode");
    chk_pullup_global: assert property (
        clk_en && global_pullup_disable |=> !pad_pullup_en[2])
        else $error("pull-up on despite global disable");
    chk_pullup_output: assert property (
        clk_en && !pin_direction_bit[4] |=> !pad_pullup_en[4])
        else $error("pull-up on for output pin");
    chk_od_no_high: assert property (
        clk_en && open_drain_enable_ff[5] |=> !(pad_oe[5] && pad_out[5]))
        else $error("open drain drove high");
    chk_pushpull_drive: assert property (
        clk_en && !open_drain_enable_ff[0] && !pin_direction_bit[0]
        |=> pad_oe[0] && pad_out[0] == $past(drive_data[0]))
        else $error("push-pull output wrong");
    chk_slew_follow: assert property (
        clk_en && aresetn |=>
        pad_slew_limit == $past(slew_limit_enable_ff[5:0]))
        else $error("slew control mismatch");
    chk_unimpl_zero: assert property (
        (open_drain_enable_ff & ~pac_pkg::MASK_DRIVE) == 8'h00 &&
        (analog_select_ff & ~pac_pkg::MASK_ANALOG) == 8'h00)
        else $error("unimplemented bit set");
    chk_reset_values: assert property (disable iff (1'b0)
        !aresetn |=> analog_select_ff == pac_pkg::RST_ANALOG &&
        open_drain_enable_ff == pac_pkg::RST_OPEN_DRAIN)
        else $error("reset value wrong");
    chk_analog_read: assert property (
        clk_en && analog_select_ff[4] |=> !port_value[4])
        else $error("analog pin read nonzero");
    chk_buf_vector: assert property (
        clk_en && aresetn |=> pad_in_buf_en == ~$past(analog_select_ff[5:0]))
        else $error("input buffer enables wrong");
    chk_od_sink: assert property (
        clk_en && open_drain_enable_ff[1] && !pin_direction_bit[1] &&
        !drive_data[1] |=> pad_oe[1] && !pad_out[1])
        else $error("open drain did not sink");
    chk_port_digital: assert property (
        clk_en && !analog_select_ff[0] |=>
        port_value[0] == $past(pin_stable_ff[0]))
        else $error("digital pin value wrong");
    chk_pullup_input: assert property (
        clk_en && aresetn && weak_pullup_enable_ff[3] &&
        !global_pullup_disable && pin_direction_bit[3] |=> pad_pullup_en[3])
        else $error("pull-up missing on input pin");

    // -----------------------------------------------------------------
    // Bus checks
    // -----------------------------------------------------------------
    chk_wr_mapped_ok: assert property (
        clk_en && do_write && write_hit |=> s_axi_bvalid &&
        s_axi_bresp == pac_pkg::RESP_OKAY)
        else $error("mapped write not acknowledged");
    chk_wr_unmapped: assert property (
        clk_en && do_write && !write_hit |=> s_axi_bvalid &&
        s_axi_bresp == pac_pkg::RESP_SLVERR && $stable(analog_select_ff))
        else $error("unmapped write not refused");
    chk_rd_accept: assert property (
        clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read accepted without response");
    chk_rd_unmapped: assert property (
        s_axi_rvalid && s_axi_rresp == pac_pkg::RESP_SLVERR |->
        s_axi_rdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    chk_freeze_state: assert property (
        !clk_en |=> $stable(analog_select_ff) && $stable(pad_oe) &&
        $stable(s_axi_bvalid) && $stable(pad_pullup_en))
        else $error("state moved while clock enable low");

    cov_write: cover property (s_axi_bvalid && s_axi_bready);
    cov_read: cover property (s_axi_rvalid && s_axi_rready);
    cov_od_low: cover property (pad_oe[0] && open_drain_enable_ff[0]);
    cov_pullup: cover property (pad_pullup_en[1]);
    cov_wr_refused: cover property (
        s_axi_bvalid && s_axi_bresp == pac_pkg::RESP_SLVERR);

endmodule : pac_port_cfg

// [src/pac_pkg.sv]
package pac_pkg;
    // -----------------------------------------------------------------
    // Register byte addresses
    // -----------------------------------------------------------------
    localparam logic [3:0] ADDR_ANALOG_SELECT  = 4'h0;
    localparam logic [3:0] ADDR_WEAK_PULLUP    = 4'h4;
    localparam logic [3:0] ADDR_OPEN_DRAIN     = 4'h8;
    localparam logic [3:0] ADDR_SLEW_LIMIT     = 4'hc;
    // -----------------------------------------------------------------
    // Implemented bit masks
    // -----------------------------------------------------------------
    localparam logic [7:0] MASK_ANALOG         = 8'h17;
    localparam logic [7:0] MASK_PULLUP         = 8'h3f;
    localparam logic [7:0] MASK_DRIVE          = 8'h37;
    // -----------------------------------------------------------------
    // Reset values
    // -----------------------------------------------------------------
    localparam logic [7:0] RST_ANALOG          = 8'h17;
    localparam logic [7:0] RST_PULLUP          = 8'h3f;
    localparam logic [7:0] RST_OPEN_DRAIN      = 8'h00;
    localparam logic [7:0] RST_SLEW            = 8'h37;
    // -----------------------------------------------------------------
    // AXI responses
    // -----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY           = 2'h0;
    localparam logic [1:0] RESP_SLVERR         = 2'h2;
endpackage : pac_pkg

// [dv/pac_port_cfg_tb.sv]
`timescale 1ns/10ps
module testbench;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic        aclk, aresetn, clk_en;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, rd;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp;
    logic        gpd;
    logic [5:0]  dir, pin_in, drive;
    logic [5:0]  pad_out, pad_oe, buf_en, pu_en, slew, port_value;
    int          bad_count, num_checks;
    logic [3:0]  adr [4];
    logic [7:0]  rst_v [4];
    logic [7:0]  msk [4];

    pac_port_cfg pac_port_cfg_inst (
        .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .global_pullup_disable(gpd),
        .pin_direction_bit(dir), .pin_in(pin_in), .drive_data(drive),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_in_buf_en(buf_en),
        .pad_pullup_en(pu_en), .pad_slew_limit(slew),
        .port_value(port_value));

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                             output logic [1:0] r);
        int n;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hf;
        wvalid <= 1'b1; bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
        if (n >= 100) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : axi_write

    task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (n >= 100) begin
            bad_count++;
            tally_and_finish();
        end
    endtask : axi_read

    task automatic settle();
        repeat (8) @(posedge aclk);
    endtask : settle

    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        bad_count = 0; num_checks = 0;
        aresetn = 1'b0; clk_en = 1'b1;
        awaddr = 4'h0; araddr = 4'h0; wstrb = 4'h0; wdata = 32'h0;
        awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
        arvalid = 1'b0; rready = 1'b0;
        gpd = 1'b0; dir = 6'h3f; pin_in = 6'h3f; drive = 6'h00;
        adr = '{pac_pkg::ADDR_ANALOG_SELECT, pac_pkg::ADDR_WEAK_PULLUP,
                pac_pkg::ADDR_OPEN_DRAIN, pac_pkg::ADDR_SLEW_LIMIT};
        rst_v = '{8'h17, 8'h3f, 8'h00, 8'h37};
        msk = '{8'h17, 8'h3f, 8'h37, 8'h37};
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        settle();
        check("slew after reset", {26'h0, slew}, 32'h37);
        check("pullup after reset", {26'h0, pu_en}, 32'h3f);
        check("in buf after reset", {26'h0, buf_en}, 32'h28);
        check("value analog pins", {26'h0, port_value}, 32'h28);
        for (int i = 0; i < 4; i++) begin
            axi_read(adr[i], rd, rsp);
            check("reset value", rd, {24'h0, rst_v[i]});
            check("read resp", {30'h0, rsp}, 32'h0);
            axi_write(adr[i], 32'hffff_ffff, rsp);
            check("write resp", {30'h0, rsp}, 32'h0);
            axi_read(adr[i], rd, rsp);
            check("masked value", rd, {24'h0, msk[i]});
        end
        axi_write(4'h1, 32'hffff_ffff, rsp);
        check("unmapped resp", {30'h0, rsp}, {30'h0, pac_pkg::RESP_SLVERR});
        axi_read(4'h1, rd, rsp);
        check("unmapped rd resp", {30'h0, rsp},
              {30'h0, pac_pkg::RESP_SLVERR});
        check("unmapped rd data", rd, 32'h0);
        axi_read(pac_pkg::ADDR_ANALOG_SELECT, rd, rsp);
        check("analog kept", rd, 32'h17);
        axi_write(pac_pkg::ADDR_ANALOG_SELECT, 32'h0, rsp);
        settle();
        check("in buf digital", {26'h0, buf_en}, 32'h3f);
        check("value digital", {26'h0, port_value}, 32'h3f);
        clk_en <= 1'b0;
        gpd <= 1'b1;
        settle();
        check("pullup frozen", {26'h0, pu_en}, 32'h3f);
        clk_en <= 1'b1;
        settle();
        check("pullup global off", {26'h0, pu_en}, 32'h00);
        gpd <= 1'b0;
        dir <= 6'h0f;
        settle();
        check("pullup outputs off", {26'h0, pu_en}, 32'h0f);
        dir <= 6'h00;
        drive <= 6'h1d;
        settle();
        check("od enable", {26'h0, pad_oe}, 32'h2a);
        check("od data", {26'h0, pad_out}, 32'h08);
        axi_write(pac_pkg::ADDR_OPEN_DRAIN, 32'h0, rsp);
        settle();
        check("pp enable", {26'h0, pad_oe}, 32'h3f);
        check("pp data", {26'h0, pad_out}, 32'h1d);
        check("slew set", {26'h0, slew}, 32'h37);
        axi_write(pac_pkg::ADDR_SLEW_LIMIT, 32'h0, rsp);
        settle();
        check("slew clear", {26'h0, slew}, 32'h00);
        dir <= 6'h3f;
        axi_write(pac_pkg::ADDR_ANALOG_SELECT, 32'h10, rsp);
        settle();
        check("in buf pin4", {26'h0, buf_en}, 32'h2f);
        check("value pin4", {26'h0, port_value}, 32'h2f);
        pin_in <= 6'h15;
        settle();
        check("value pin4 low", {26'h0, port_value}, 32'h05);
        tally_and_finish();
    end
endmodule : testbench
